// ==== pkg/tocu_pkg.sv ====
/*
  tocu_pkg: register indices, field positions, reset values and the
  pin action coding of the timer output compare unit.
  Assumes a 32-bit APB slave where byte address = 4 * register index.
*/
package tocu_pkg;

  // channel count: four compare channels plus the shared fifth
  localparam int NCH = 5;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_COUNT_HI   = 14'h100E;
  localparam logic [13:0] IDX_COUNT_LO   = 14'h100F;
  localparam logic [13:0] IDX_FORCE      = 14'h100B;
  localparam logic [13:0] IDX_CH1_MASK   = 14'h100C;
  localparam logic [13:0] IDX_CH1_DATA   = 14'h100D;
  localparam logic [13:0] IDX_PIN_CTL    = 14'h1020;
  localparam logic [13:0] IDX_IRQ_EN     = 14'h1022;
  localparam logic [13:0] IDX_FLAGS      = 14'h1023;
  localparam logic [13:0] IDX_SHARED_SEL = 14'h1026;
  // compare channels 1..4 and the shared capture/compare register
  localparam logic [13:0] IDX_CMP [NCH] = '{14'h1016, 14'h1018,
                                            14'h101A, 14'h101C,
                                            14'h101E};

  // reset values
  localparam logic [15:0] CMP_RESET   = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // field positions
  localparam int FLAG_CMP1   = 7;  // compare ch1..4 in bits 7..4
  localparam int FLAG_SHARED = 3;
  localparam int FLAG_CAP1   = 2;  // capture ch1..3 in bits 2..0
  localparam int FORCE_LSB   = 3;  // force/mask bits live in 7..3
  localparam int SEL_BIT     = 2;  // shared channel select position
  localparam int STRB_HI     = 1;  // byte lane of the upper byte
  localparam int STRB_LO     = 0;

  // counter advances once every PRESCALE_LAST+1 bus clocks
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // pin action coding per channel (mode bit, level bit)
  typedef enum logic [1:0] {
    TOCU_DISC   = 2'b00,
    TOCU_TOGGLE = 2'b01,
    TOCU_LOW    = 2'b10,
    TOCU_HIGH   = 2'b11
  } tocu_pin_mode_t;

  // new pin level for one action
  function automatic logic tocu_pin_next(input logic [1:0] code,
                                         input logic       cur);
    case (tocu_pin_mode_t'(code))
      TOCU_TOGGLE: tocu_pin_next = ~cur;
      TOCU_LOW:    tocu_pin_next = 1'b0;
      TOCU_HIGH:   tocu_pin_next = 1'b1;
      default:     tocu_pin_next = cur;
    endcase
  endfunction

endpackage

// ==== pkg/tocu_cmp_if.sv ====
/*
  tocu_cmp_if: carries the counter, compare values and match results
  between the unit's register side and its comparator bank.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/10ps
interface tocu_cmp_if;
  logic        tick;               // counter advances this cycle
  logic [15:0] count_next;         // value the counter takes on tick
  logic [15:0] cmp [tocu_pkg::NCH];
  logic [4:0]  inhibit;            // upper-byte write just happened
  logic [4:0]  enable;             // channel runs its comparator
  logic [4:0]  match;              // bit 0 is channel 1

  modport ctrl (output tick, output count_next, output cmp,
                output inhibit, output enable, input match);
  modport bank (input tick, input count_next, input cmp,
                input inhibit, input enable, output match);
endinterface

// ==== hw/tocu_match.sv ====
/*
  tocu_match: one 16-bit comparator per channel, evaluated against
  the counter's next value so a match lines up with the increment.
  Assumes the parent supplies tick as a one-cycle enable.
*/
`timescale 1ns/10ps
module tocu_match (
  tocu_cmp_if.bank cmp_bus
);

  // equality gated by enable and by the upper-byte write inhibit
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] b,
                               input logic        en,
                               input logic        inh);
    hit = en && !inh && (a == b);
  endfunction

  // evaluated only on counter steps so each value matches once
  always_comb begin
    for (int i = 0; i < tocu_pkg::NCH; i++) begin
      cmp_bus.match[i] = cmp_bus.tick &&
                         hit(cmp_bus.count_next, cmp_bus.cmp[i],
                             cmp_bus.enable[i], cmp_bus.inhibit[i]);
    end
  end

endmodule

// ==== hw/tocu_top.sv ====
/*
  tocu_top: output compare part of a 16-bit free-running timer with an
  APB register slave, forced compares, channel-1 mask/data pin control,
  pin action decoding, event flags and a channel interrupt request.
  Assumes pclk at 50 MHz, presetn asynchronous active low, capture
  inputs asynchronous to pclk.
*/
// Register access over APB was decided locally.
// Summary of operation
// (R1) each compare channel has a 16-bit read/write value, reset to FFFF
// (R2) writing a value's upper byte blocks that channel's compare a cycle
// (R3) software wanting coherency accesses the value as one 16-bit word
// (R4) counter equal to a channel value triggers its pin action
// (R5) forced compare acts on the pin but does not set the flag
// (R6) forced actions happen at the next counter increment
// (R7) force bits 7..3 are channels 1..5; zero writes ignored; reads zero
// (R8) software should not force a channel set to toggle
// (R9) channel-1 mask bits 7..3 pick pins PA7..PA3; low bits read zero
// (R10) channel-1 match drives data bits onto every masked pin
// (R11) counter readable, read-only, reset to zero
// (R12) reading the counter's upper byte latches the low byte for next read
// (R13) mode/level pair: 00 off, 01 toggle, 10 low, 11 high
// (R14) pin control holds channel 2..5 pairs in 7:6, 5:4, 3:2, 1:0
// (R15) fifth compare runs only while the shared select bit is clear
// (R16) interrupt requested when a flag and its enable are both set
// (R17) enable bit 3 follows whichever function the select bit picks
// (R18) enable register mirrors flag layout bit for bit, resets zero
// (R19) a flag clears only when a one is written to its position
// (R20) compare flag sets on every counter match
// (R21) capture flag sets on every detected input edge
// (R22) shared flag set by capture 4 or compare 5 per the select bit
// (R23) pin action taken on every match regardless of the flag
// (R24) channel 1 wins when it and another channel act on one pin
`timescale 1ns/10ps
module tocu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  capture_inputs,
  output logic      [4:0]  port_a_upper_pins,
  output logic      [4:0]  port_a_upper_oe,
  output logic             irq
);

  tocu_cmp_if cmp_bus ();

  logic [15:0] free_running_count;
  logic [15:0] cmp_val [tocu_pkg::NCH];
  logic [7:0]  pin_action_control;
  logic [7:0]  channel_interrupt_enable;
  logic [7:0]  channel_event_flags;
  logic [4:0]  ch1_pin_select_mask;
  logic [4:0]  ch1_pin_data;
  logic [4:0]  force_pend;
  logic [4:0]  force_wr;
  logic        shared_channel_select;
  logic [4:0]  inhibit;
  logic [1:0]  prescale;
  logic        tick;
  logic [7:0]  lo_latch;
  logic        lo_latch_valid;
  logic [3:0]  cap_s1;
  logic [3:0]  cap_s2;
  logic [3:0]  cap_s3;
  logic [3:0]  cap_edge;
  logic [4:0]  act;
  logic [4:0]  next_pins;
  logic [4:0]  next_oe;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        done;
  logic        wr_done;
  logic [13:0] idx;

  // apb phases; the access phase always completes in one cycle
  assign setup   = psel && !penable;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign idx     = paddr[15:2];

  // prescale divider: one-cycle enable for each counter step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 2'h0;
    end else begin
      prescale <= tick ? 2'h0 : prescale + 2'h1;
    end
  end
  assign tick = (prescale == tocu_pkg::PRESCALE_LAST);

  // free-running counter, never written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_running_count <= tocu_pkg::COUNT_RESET; // R11
    end else if (tick) begin
      free_running_count <= cmp_bus.count_next;
    end
  end

  // comparator bank hookup
  assign cmp_bus.tick       = tick;
  assign cmp_bus.count_next = free_running_count + 16'h0001;
  assign cmp_bus.cmp        = cmp_val;
  assign cmp_bus.inhibit    = inhibit;
  // fifth comparator idles while the shared register captures
  assign cmp_bus.enable     = {!shared_channel_select, 4'hF}; // R15

  tocu_match u_match (
    .cmp_bus (cmp_bus.bank)
  );

  // compare values; shared register also loads on capture 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < tocu_pkg::NCH; i++) begin
        cmp_val[i] <= tocu_pkg::CMP_RESET; // R1
      end
      inhibit <= 5'h00;
    end else begin
      inhibit <= 5'h00;
      for (int i = 0; i < tocu_pkg::NCH; i++) begin
        // software writes are ignored while channel 5 acts as capture
        if (wr_done && idx == tocu_pkg::IDX_CMP[i] &&
            !(i == tocu_pkg::NCH - 1 && shared_channel_select)) begin
          if (pstrb[tocu_pkg::STRB_HI]) begin
            cmp_val[i][15:8] <= pwdata[15:8]; // R3
            inhibit[i]       <= 1'b1; // R2
          end
          if (pstrb[tocu_pkg::STRB_LO]) begin
            cmp_val[i][7:0] <= pwdata[7:0];
          end
        end
      end
      if (shared_channel_select && cap_edge[3]) begin
        cmp_val[tocu_pkg::NCH-1] <= free_running_count;
      end
    end
  end

  // control registers; mask and data keep only bits 7..3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_action_control       <= tocu_pkg::BYTE_RESET;
      channel_interrupt_enable <= tocu_pkg::BYTE_RESET;
      ch1_pin_select_mask      <= 5'h00;
      ch1_pin_data             <= 5'h00;
      shared_channel_select    <= 1'b0;
    end else if (wr_done && pstrb[tocu_pkg::STRB_LO]) begin
      case (idx)
        tocu_pkg::IDX_PIN_CTL:
          pin_action_control <= pwdata[7:0]; // R14
        tocu_pkg::IDX_IRQ_EN:
          channel_interrupt_enable <= pwdata[7:0]; // R18
        tocu_pkg::IDX_CH1_MASK:
          ch1_pin_select_mask <= pwdata[7:tocu_pkg::FORCE_LSB]; // R9
        tocu_pkg::IDX_CH1_DATA:
          ch1_pin_data <= pwdata[7:tocu_pkg::FORCE_LSB];
        tocu_pkg::IDX_SHARED_SEL:
          shared_channel_select <= pwdata[tocu_pkg::SEL_BIT];
        default: ;
      endcase
    end
  end

  // write bits 7..3 reversed so channel 1 lands in bit 0
  assign force_wr = {<<{pwdata[7:tocu_pkg::FORCE_LSB]}};

  // force bits wait for the next counter step; a new write wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_pend <= 5'h00;
    end else begin
      force_pend <= (force_pend & {5{!tick}}) |
                    ((wr_done && pstrb[tocu_pkg::STRB_LO] &&
                      idx == tocu_pkg::IDX_FORCE) ?
                     force_wr : 5'h00); // R7
    end
  end

  // capture inputs are asynchronous: two flops, then edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1 <= 4'h0;
      cap_s2 <= 4'h0;
      cap_s3 <= 4'h0;
    end else begin
      cap_s1 <= capture_inputs;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end
  // rising edges only; edge selection lives elsewhere
  assign cap_edge = cap_s2 & ~cap_s3;

  // actions: real matches plus forces taken at the counter step
  assign act = cmp_bus.match | (force_pend & {5{tick}} &
               {!shared_channel_select, 4'hF}); // R4 R5 R6 R23

  // pin levels: channels 2..5 first, then channel 1 overrides
  always_comb begin
    next_pins = port_a_upper_pins;
    next_oe   = port_a_upper_oe;
    for (int c = 1; c < tocu_pkg::NCH; c++) begin
      // channel c+1 owns pin bit 4-c, its pair at bits 7-2(c-1)
      if (act[c]) begin
        next_pins[4-c] = tocu_pkg::tocu_pin_next(
          pin_action_control[9-2*c -: 2], port_a_upper_pins[4-c]); // R13
      end
      next_oe[4-c] = ch1_pin_select_mask[4-c] ||
                     (pin_action_control[9-2*c -: 2] != 2'b00 &&
                      !(c == tocu_pkg::NCH - 1 && shared_channel_select));
    end
    next_oe[4] = ch1_pin_select_mask[4];
    if (act[0]) begin
      // channel 1 applied last so it wins any shared pin
      next_pins = (next_pins & ~ch1_pin_select_mask) |
                  (ch1_pin_data & ch1_pin_select_mask); // R10 R24
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_upper_pins <= 5'h00;
      port_a_upper_oe   <= 5'h00;
    end else begin
      port_a_upper_pins <= next_pins;
      port_a_upper_oe   <= next_oe;
    end
  end

  // event flags: hardware set beats a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_event_flags <= tocu_pkg::BYTE_RESET;
    end else begin
      channel_event_flags <=
        (channel_event_flags &
         ~((wr_done && pstrb[tocu_pkg::STRB_LO] &&
            idx == tocu_pkg::IDX_FLAGS) ? pwdata[7:0] : 8'h00)) | // R19
        {cmp_bus.match[0], cmp_bus.match[1],
         cmp_bus.match[2], cmp_bus.match[3], // R20
         shared_channel_select ? cap_edge[3] : cmp_bus.match[4], // R22
         cap_edge[0], cap_edge[1], cap_edge[2]}; // R21
    end
  end

  // interrupt: bit 3 enable serves whichever shared function is live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(channel_event_flags & channel_interrupt_enable); // R16 R17
    end
  end

  // read mux; values sampled in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (idx)
      tocu_pkg::IDX_COUNT_HI: next_rdata[15:0] = free_running_count;
      tocu_pkg::IDX_COUNT_LO:
        next_rdata[7:0] = lo_latch_valid ? lo_latch
                                         : free_running_count[7:0]; // R12
      tocu_pkg::IDX_FORCE:      next_rdata = 32'h0000_0000; // R7
      tocu_pkg::IDX_CH1_MASK:   next_rdata[7:3] = ch1_pin_select_mask;
      tocu_pkg::IDX_CH1_DATA:   next_rdata[7:3] = ch1_pin_data;
      tocu_pkg::IDX_PIN_CTL:    next_rdata[7:0] = pin_action_control;
      tocu_pkg::IDX_IRQ_EN:     next_rdata[7:0] = channel_interrupt_enable;
      tocu_pkg::IDX_FLAGS:      next_rdata[7:0] = channel_event_flags;
      tocu_pkg::IDX_SHARED_SEL:
        next_rdata[tocu_pkg::SEL_BIT] = shared_channel_select;
      default: begin
        next_err = 1'b1;
        for (int i = 0; i < tocu_pkg::NCH; i++) begin
          if (idx == tocu_pkg::IDX_CMP[i]) begin
            next_rdata[15:0] = cmp_val[i];
            next_err         = 1'b0;
          end
        end
      end
    endcase
  end

  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // low-byte latch lives for exactly one following transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_latch       <= 8'h00;
      lo_latch_valid <= 1'b0;
    end else begin
      if (setup && !pwrite && idx == tocu_pkg::IDX_COUNT_HI) begin
        lo_latch <= free_running_count[7:0]; // R12
      end
      if (done) begin
        lo_latch_valid <= !pwrite && idx == tocu_pkg::IDX_COUNT_HI;
      end
    end
  end

  // checks
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  inhibit_after_write_a: assert property ( // R2
    (wr_done && pstrb[tocu_pkg::STRB_HI] && idx == tocu_pkg::IDX_CMP[1])
    |=> !cmp_bus.match[1])
    else $error("compare fired right after upper byte write");

  match_sets_flag_a: assert property ( // R20
    (tick && !inhibit[0] && cmp_bus.count_next == cmp_val[0])
    |=> channel_event_flags[tocu_pkg::FLAG_CMP1])
    else $error("channel 1 match did not set its flag");

  force_no_flag_a: assert property ( // R5
    (tick && force_pend[0] && !cmp_bus.match[0] &&
     !channel_event_flags[tocu_pkg::FLAG_CMP1])
    |=> !channel_event_flags[tocu_pkg::FLAG_CMP1])
    else $error("forced compare set a flag");

  force_drives_pin_a: assert property ( // R6
    (tick && force_pend[1] && pin_action_control[7:6] == 2'b11 &&
     !(act[0] && ch1_pin_select_mask[3]))
    |=> port_a_upper_pins[3])
    else $error("forced set-high not seen at counter step");

  toggle_flips_pin_a: assert property ( // R13
    (act[2] && pin_action_control[5:4] == 2'b01 &&
     !(act[0] && ch1_pin_select_mask[2]))
    |=> port_a_upper_pins[2] != $past(port_a_upper_pins[2]))
    else $error("toggle action did not flip pin");

  ch1_data_out_a: assert property ( // R10
    act[0] |=> ((port_a_upper_pins ^ $past(ch1_pin_data)) &
                $past(ch1_pin_select_mask)) == 5'h00)
    else $error("masked pins differ from channel 1 data");

  irq_follows_flags_a: assert property ( // R16
    (channel_event_flags[tocu_pkg::FLAG_CAP1] &&
     channel_interrupt_enable[tocu_pkg::FLAG_CAP1]) |=> irq)
    else $error("enabled flag raised no interrupt");

  zero_keeps_flag_a: assert property ( // R19
    (wr_done && idx == tocu_pkg::IDX_FLAGS && !pwdata[7] &&
     channel_event_flags[tocu_pkg::FLAG_CMP1])
    |=> channel_event_flags[tocu_pkg::FLAG_CMP1])
    else $error("zero write cleared a flag");

  shared_capture_mode_a: assert property ( // R15
    (shared_channel_select && !cap_edge[3]) |-> !cmp_bus.match[4])
    else $error("fifth compare ran in capture mode");

  match_ch1_c: cover property (cmp_bus.match[0]);
  forced_ch2_c: cover property (tick && force_pend[1]);
  count_latch_c: cover property (done && idx == tocu_pkg::IDX_COUNT_LO &&
                                 lo_latch_valid);

endmodule

// ==== bench/tocu_port_model.sv ====
/*
  tocu_port_model: port A pads and capture pins seen from the board.
  Assumes pull-ups on the pads and requests driven on the pclk edge.
*/
`timescale 1ns/10ps
module tocu_port_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] edge_req,
  input  wire logic [4:0] pins,
  input  wire logic [4:0] pins_oe,
  output logic      [3:0] capture_inputs,
  output logic      [4:0] pad_level
);
  logic [2:0] hold [4];

  // a released pad floats up to its pull-up, never the last level
  assign pad_level = (pins & pins_oe) | ~pins_oe;

  // one request gives one rising edge, held eight clocks so the
  // two-flop synchroniser cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!presetn) begin
        capture_inputs[i] <= 1'b0;
        hold[i]           <= 3'h0;
      end else if (edge_req[i]) begin
        capture_inputs[i] <= 1'b1;
        hold[i]           <= 3'h7;
      end else if (hold[i] != 3'h0) begin
        hold[i] <= hold[i] - 3'h1;
      end else begin
        capture_inputs[i] <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/timer_output_compare_unit_tb.sv ====
/*
  timer_output_compare_unit_tb: register level checks of the compare
  unit over APB, with the port model on the pins.
  Assumes tocu_pkg compiled first and a one-cycle APB access phase.
*/
`timescale 1ns/10ps
module timer_output_compare_unit_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  capture_inputs;
  logic [4:0]  pins;
  logic [4:0]  pins_oe;
  logic        irq;
  logic [3:0]  edge_req;
  logic [4:0]  pad_level;
  logic [31:0] d;
  logic [31:0] v;
  logic        e;
  int          num_errors;
  int          checks_done;

  tocu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_inputs(capture_inputs), .port_a_upper_pins(pins),
    .port_a_upper_oe(pins_oe), .irq(irq));

  tocu_port_model u_port (.pclk(pclk), .presetn(presetn),
    .edge_req(edge_req), .pins(pins), .pins_oe(pins_oe),
    .capture_inputs(capture_inputs), .pad_level(pad_level));

  // verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; last=0 keeps psel up for a back-to-back setup
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input logic [31:0] wd, input logic [3:0] st,
                     input bit last, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (last) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'hF, 1'b1, d, e);
  endtask

  task automatic rd(input logic [13:0] idx);
    apb(1'b0, idx, 32'h0, 4'h0, 1'b1, d, e);
  endtask

  task automatic pulse(input logic [3:0] p);
    edge_req <= p;
    @(posedge pclk);
    edge_req <= 4'h0;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    edge_req = 4'h0;
    presetn = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values
    for (int i = 0; i < 5; i++) begin
      rd(tocu_pkg::IDX_CMP[i]);
      chk("cmp reset", 32'h0000FFFF, d);
    end
    rd(tocu_pkg::IDX_PIN_CTL);
    chk("pin ctl reset", 32'h0, d);
    rd(tocu_pkg::IDX_IRQ_EN);
    chk("irq en reset", 32'h0, d);
    // read/write, read masks, unmapped place
    apb(1'b1, tocu_pkg::IDX_CMP[3], 32'hA55A, 4'h3, 1'b1, d, e);
    rd(tocu_pkg::IDX_CMP[3]);
    chk("cmp rw", 32'h0000A55A, d);
    wr(tocu_pkg::IDX_FORCE, 32'hFF);
    rd(tocu_pkg::IDX_FORCE);
    chk("force read", 32'h0, d);
    wr(tocu_pkg::IDX_IRQ_EN, 32'hFF);
    rd(tocu_pkg::IDX_IRQ_EN);
    chk("irq en rw", 32'hFF, d);
    wr(tocu_pkg::IDX_IRQ_EN, 32'h0);
    rd(14'h1001);
    chk("unmapped err", 32'h1, {31'h0, e});
    // low byte latched by an upper-byte read, at varying phases
    for (int k = 0; k < 4; k++) begin
      repeat (k) @(posedge pclk);
      apb(1'b0, tocu_pkg::IDX_COUNT_HI, 32'h0, 4'h0, 1'b0, v, e);
      apb(1'b0, tocu_pkg::IDX_COUNT_LO, 32'h0, 4'h0, 1'b1, d, e);
      chk("count latch", {24'h0, v[7:0]}, d);
    end
    // forced actions, two layouts of the pin control pairs
    for (int k = 0; k < 2; k++) begin
      wr(tocu_pkg::IDX_PIN_CTL, k ? 32'hBB : 32'hEE);
      wr(tocu_pkg::IDX_FORCE, 32'h78);
      repeat (5) @(posedge pclk);
      chk("forced pins", k ? 32'h5 : 32'hA, {28'h0, pins[3:0]});
    end
    rd(tocu_pkg::IDX_FLAGS);
    chk("no force flag", 32'h0, d);
    wr(tocu_pkg::IDX_PIN_CTL, 32'h0);
    // enables leave the flop one edge after the write lands
    @(posedge pclk);
    chk("pins released", 32'h0, {27'h0, pins_oe});
    chk("pads pulled", 32'h1F, {27'h0, pad_level});
    // channel 1 data on masked pins beats the other channels
    wr(tocu_pkg::IDX_PIN_CTL, 32'hFF);
    wr(tocu_pkg::IDX_CH1_MASK, 32'hFF);
    rd(tocu_pkg::IDX_CH1_MASK);
    chk("mask read", 32'hF8, d);
    wr(tocu_pkg::IDX_CH1_DATA, 32'h50);
    wr(tocu_pkg::IDX_FORCE, 32'hF8);
    repeat (5) @(posedge pclk);
    chk("ch1 wins", 32'h0A, {27'h0, pins});
    wr(tocu_pkg::IDX_CH1_MASK, 32'h80);
    wr(tocu_pkg::IDX_CH1_DATA, 32'h80);
    wr(tocu_pkg::IDX_FORCE, 32'h80);
    repeat (5) @(posedge pclk);
    chk("masked pins", 32'h1A, {27'h0, pins});
    // real match toggles ch2; toggle is never forced
    wr(tocu_pkg::IDX_CH1_MASK, 32'h0);
    wr(tocu_pkg::IDX_PIN_CTL, 32'h40);
    wr(tocu_pkg::IDX_IRQ_EN, 32'h40);
    rd(tocu_pkg::IDX_COUNT_HI);
    v = d + 32'h10;
    apb(1'b1, tocu_pkg::IDX_CMP[1], {16'h0, v[15:0]}, 4'h3, 1'b1, d, e);
    for (int n = 0; n < 60; n++) begin
      rd(tocu_pkg::IDX_FLAGS);
      if (d[6] === 1'b1) break;
    end
    chk("match flag", 32'h40, d);
    chk("irq on", 32'h1, {31'h0, irq});
    chk("toggled pin", 32'h0, {31'h0, pins[3]});
    wr(tocu_pkg::IDX_FLAGS, 32'hBF);
    rd(tocu_pkg::IDX_FLAGS);
    chk("flag kept", 32'h40, d);
    wr(tocu_pkg::IDX_FLAGS, 32'h40);
    rd(tocu_pkg::IDX_FLAGS);
    chk("flag cleared", 32'h0, d);
    chk("irq off", 32'h0, {31'h0, irq});
    // shared channel as capture 4, then back to compare 5
    wr(tocu_pkg::IDX_SHARED_SEL, 32'h04);
    wr(tocu_pkg::IDX_CMP[4], 32'h1234);
    rd(tocu_pkg::IDX_CMP[4]);
    chk("shared locked", 32'h0000FFFF, d);
    wr(tocu_pkg::IDX_IRQ_EN, 32'h08);
    pulse(4'h8);
    rd(tocu_pkg::IDX_FLAGS);
    chk("capture4 flag", 32'h08, d);
    chk("capture4 irq", 32'h1, {31'h0, irq});
    // capture pin 0 feeds flag bit 2 in the design's wiring
    pulse(4'h1);
    rd(tocu_pkg::IDX_FLAGS);
    chk("capture1 flag", 32'h0C, d);
    wr(tocu_pkg::IDX_FLAGS, 32'h0C);
    wr(tocu_pkg::IDX_SHARED_SEL, 32'h0);
    wr(tocu_pkg::IDX_CMP[4], 32'h1234);
    rd(tocu_pkg::IDX_CMP[4]);
    chk("shared cmp", 32'h00001234, d);
    conclude();
  end
endmodule
